// file: rtl/mmch_seq.sv
// Card-link command sequencer with APB registers and one interrupt.
// Assumes the card answers on cmd_in/dat_in; the card clock is ours.
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// Operation
// [RULE1] Software sets DMA setup before multiblock read or write commands.
// [RULE2] Auto DMA mode is unavailable for open-ended multiblock transfers.
// [RULE3] Read end shown by busy clearing, transfer-end or block-count-end flag.
// [RULE4] Abort bit stops the sequence; early abort loses the response.
// [RULE5] Software holds read-continue until the response is fully captured.
// [RULE6] After non-data commands watch data line; report card busy bit. Code watches it only after commands that get a response.
// [RULE7] CRC error flag clears by reading it as one, then writing zero.
// [RULE8] Cards drop out of identification when their bit differs.
// [RULE9] Card completing identification enters acknowledge state.
// [RULE10] Card holds data line busy during long flash operations.
// [RULE11] CRC mismatch sets error flag; enabled flag raises the interrupt. Code checks responses only with C_CRCCHK set, never long ones.
module mmch_seq (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire logic         cmd_in,
  input  wire logic         dat_in,
  output mmch_pkg::mmch_pins_t pins,
  output logic              irq,
  output logic              dma_req
);
  import mmch_pkg::*;

  typedef struct packed {
    mmch_state_t                 st;
    mmch_pins_t                  pins;
    logic [7:0]                  div;
    logic [7:0]                  cdiv;
    logic                        cmd_s1;
    logic                        cmd_s2;
    logic                        dat_s1;
    logic                        dat_s2;
    logic [47:0]                 sh;
    logic [7:0]                  cnt;
    logic [15:0]                 dcnt;
    logic [7:0]                  bsh;
    logic [15:0]                 blk;
    logic [31:0]                 arg;
    logic [12:0]                 ctrl;
    logic                        read_continue_bit;
    logic [11:0]                 blksz;
    logic [15:0]                 blkcnt;
    logic [1:0]                  dma;
    logic [I_W-1:0]              sts;
    logic [I_W-1:0]              mask;
    logic                        crc_armed;
    logic                        card_busy;
    logic [7:0]                  rx_byte;
    logic [7:0]                  tx_byte;
    logic                        rx_full;
    logic                        tx_full;
    logic [RESP_BYTES-1:0][7:0]  resp;
    logic [4:0]                  respd;
    logic                        pready;
    logic                        pslverr;
    logic [31:0]                 prdata;
    logic                        irq;
    logic                        dma_req;
  } mmch_st_t;

  mmch_st_t       s;
  mmch_st_t       n;
  logic           wr;
  logic           rd;
  logic           tick;
  logic           stall;
  logic           pause;
  logic           auto_eff;
  logic           crc_bad;
  logic           blk_end;
  logic           txb;
  logic [15:0]    nbits;
  logic [15:0]    dm1;
  logic [15:0]    nblk;
  logic [I_W-1:0] ev;
  logic [I_W-1:0] sts_clr;
  logic           c7_clr;
  logic           c7_en;
  logic           c7_din;
  logic           c16_clr;
  logic           c16_en;
  logic           c16_din;
  logic [6:0]     crc7;
  logic [15:0]    crc16;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic is_resp(input logic [7:0] a);
    return (a >= OFF_RESP) && (a < OFF_RESPD) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic [4:0] resp_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - OFF_RESP;
    return d[6:2];
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    case (a)
      OFF_ARG, OFF_CTRL, OFF_COMMAND_STATUS_REG, OFF_ISTS, OFF_IMASK, OFF_BLK,
      OFF_DMA, OFF_DATA, OFF_CDIV, OFF_RESPD: return 1'b1;
      default: return is_resp(a);
    endcase
  endfunction

  function automatic logic [31:0] rd_mux(input mmch_st_t r,
                                         input logic [7:0] a);
    case (a)
      OFF_ARG:   return r.arg;
      OFF_CTRL:  return {13'h0, r.read_continue_bit, 5'h00, r.ctrl};
      OFF_COMMAND_STATUS_REG:  return {28'h0, r.tx_full, r.rx_full, r.card_busy,
                         r.st != ST_IDLE};
      OFF_ISTS:  return {27'h0, r.sts};
      OFF_IMASK: return {27'h0, r.mask};
      OFF_BLK:   return {r.blkcnt, 4'h0, r.blksz};
      OFF_DMA:   return {30'h0, r.dma};
      OFF_DATA:  return {24'h0, r.rx_byte};
      OFF_CDIV:  return {24'h0, r.cdiv};
      OFF_RESPD: return {27'h0, r.respd};
      default:   return is_resp(a) ? {24'h0, r.resp[resp_idx(a)]} : 32'h0;
    endcase
  endfunction

  mmch_crc #(.W(7), .POLY(CRC7_POLY)) u_crc7 (
    .clk   (pclk),
    .rst_n (presetn),
    .clr   (c7_clr),
    .en    (c7_en),
    .din   (c7_din),
    .crc   (crc7)
  );

  mmch_crc #(.W(16), .POLY(CRC16_POLY)) u_crc16 (
    .clk   (pclk),
    .rst_n (presetn),
    .clr   (c16_clr),
    .en    (c16_en),
    .din   (c16_din),
    .crc   (crc16)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    n = s;
    wr = psel & penable & s.pready & pwrite;
    rd = psel & penable & s.pready & ~pwrite;
    ev = '0;
    sts_clr = '0;
    crc_bad = 1'b0;
    blk_end = 1'b0;
    txb = 1'b1;
    c7_clr = 1'b0;
    c7_en = 1'b0;
    c7_din = 1'b0;
    c16_clr = 1'b0;
    c16_en = 1'b0;
    c16_din = 1'b0;
    nbits = {1'b0, s.blksz, 3'b000};
    dm1 = s.dcnt - 16'h0001;
    nblk = s.blk + 16'h0001;
    n.cmd_s1 = cmd_in;
    n.cmd_s2 = s.cmd_s1;
    n.dat_s1 = dat_in;
    n.dat_s2 = s.dat_s1;
    n.pready = psel & penable & ~s.pready;
    n.pslverr = psel & penable & ~s.pready & ~mapped(paddr);
    n.prdata = (psel & penable & ~s.pready & ~pwrite) ?
               rd_mux(s, paddr) : 32'h0;
    // Auto mode is forced off for open-ended transfers
    auto_eff = s.dma[D_EN] & s.dma[D_AUTO] & ~s.ctrl[C_OPEN];  // RULE2
    // Without auto DMA, multiblock read holds between blocks until continue is set
    pause = (s.st == ST_DWAIT) & s.ctrl[C_MULTI] & ~s.read_continue_bit  // RULE5
            & ~auto_eff & (s.blk != 16'h0);
    stall = pause | ((s.st == ST_DRX) & s.rx_full) |
            ((s.st == ST_DTX) & (s.dcnt != 16'h0) & (s.dcnt <= nbits) &
             (dm1[2:0] == 3'b000) & ~s.tx_full);
    // Card clock: stops low when idle or stalled
    tick = 1'b0;
    if (s.st == ST_IDLE) begin
      n.div = 8'h00;
      n.pins.clk = 1'b0;
    end else if (!(stall && !s.pins.clk)) begin
      if (s.div >= s.cdiv) begin
        n.div = 8'h00;
        n.pins.clk = ~s.pins.clk;
        tick = s.pins.clk;
      end else begin
        n.div = s.div + 8'h01;
      end
    end
    if (tick) begin
      case (s.st)
        ST_CMD: begin
          if (s.cnt == CMD_BITS) begin
            n.pins.cmd_oe = 1'b0;
            n.cnt = 8'h00;
            c7_clr = 1'b1;
            n.st = s.ctrl[C_RESP] ? ST_RWAIT : ST_IDLE;
          end else begin
            n.pins.cmd_oe = 1'b1;
            c7_en = (s.cnt < CRC_SPAN);
            c7_din = s.sh[47];
            if (s.cnt == CRC_SPAN) begin
              n.pins.cmd_o = crc7[6];
              n.sh = {crc7[5:0], 1'b1, 41'h0};
            end else begin
              n.pins.cmd_o = s.sh[47];
              n.sh = {s.sh[46:0], 1'b0};
            end
            n.cnt = s.cnt + 8'h01;
          end
        end
        ST_RWAIT: begin
          if (!s.cmd_s2) begin
            n.st = ST_RESP;
            n.cnt = 8'h01;
            n.bsh = 8'h00;
            c7_en = 1'b1;
          end else if (s.cnt == RESP_TMO) begin
            ev[I_TOUT] = 1'b1;
            n.st = ST_IDLE;
          end else begin
            n.cnt = s.cnt + 8'h01;
          end
        end
        ST_RESP: begin
          n.bsh = {s.bsh[6:0], s.cmd_s2};
          c7_en = (s.cnt < CRC_SPAN);
          c7_din = s.cmd_s2;
          if (s.cnt[2:0] == 3'b111) begin
            n.resp[s.cnt[7:3]] = {s.bsh[6:0], s.cmd_s2};
          end
          n.cnt = s.cnt + 8'h01;
          if (s.cnt == (s.ctrl[C_LONG] ? LONG_BITS : CMD_BITS) - 8'h01)
          begin
            ev[I_RESP] = 1'b1;
            crc_bad = s.ctrl[C_CRCCHK] & ~s.ctrl[C_LONG] &     // RULE11
                      (s.bsh[6:0] != crc7);
            n.cnt = 8'h00;
            n.dcnt = 16'h0000;
            n.blk = 16'h0000;
            c16_clr = 1'b1;
            if (!s.ctrl[C_DATA]) begin
              n.st = ST_BUSY;
            end else begin
              n.st = s.ctrl[C_WRITE] ? ST_DTX : ST_DWAIT;
            end
          end
        end
        ST_BUSY: begin
          // Data line low after a plain command means card busy
          n.card_busy = ~s.dat_s2;                              // RULE6
          if (s.dat_s2) begin
            n.st = ST_IDLE;                                     // RULE6
          end
        end
        ST_DWAIT: begin
          if (!s.dat_s2) begin
            n.st = ST_DRX;
            n.dcnt = 16'h0000;
          end
        end
        ST_DRX: begin
          n.dcnt = s.dcnt + 16'h0001;
          if (s.dcnt < nbits) begin
            n.bsh = {s.bsh[6:0], s.dat_s2};
            c16_en = 1'b1;
            c16_din = s.dat_s2;
            if (s.dcnt[2:0] == 3'b111) begin
              n.rx_byte = {s.bsh[6:0], s.dat_s2};
              n.rx_full = 1'b1;
            end
          end else if (s.dcnt < nbits + 16'h0010) begin
            n.sh[15:0] = {s.sh[14:0], s.dat_s2};
          end else begin
            crc_bad = (s.sh[15:0] != crc16);                    // RULE11
            blk_end = 1'b1;
          end
        end
        ST_DTX: begin
          n.dcnt = s.dcnt + 16'h0001;
          n.pins.dat_oe = 1'b1;
          if (s.dcnt == 16'h0000) begin
            txb = 1'b0;
          end else if (s.dcnt <= nbits) begin
            if (dm1[2:0] == 3'b000) begin
              txb = s.tx_byte[7];
              n.bsh = {s.tx_byte[6:0], 1'b0};
              n.tx_full = 1'b0;
            end else begin
              txb = s.bsh[7];
              n.bsh = {s.bsh[6:0], 1'b0};
            end
            c16_en = 1'b1;
            c16_din = txb;
          end else if (s.dcnt == nbits + 16'h0001) begin
            txb = crc16[15];
            n.sh[15:0] = {crc16[14:0], 1'b0};
          end else if (s.dcnt <= nbits + 16'h0010) begin
            txb = s.sh[15];
            n.sh[15:0] = {s.sh[14:0], 1'b0};
          end else if (s.dcnt != nbits + 16'h0011) begin
            n.pins.dat_oe = 1'b0;
            n.st = ST_DBUSY;
            n.cnt = 8'h00;
          end
          n.pins.dat_o = txb;
        end
        ST_DBUSY: begin
          // Skip the status token, then wait out the card's busy
          if (s.cnt < WR_TOKEN) begin
            n.cnt = s.cnt + 8'h01;
          end else if (s.dat_s2) begin                        // RULE10
            blk_end = 1'b1;
          end
        end
        default: begin
          n.st = ST_IDLE;
        end
      endcase
    end
    if (blk_end) begin
      n.blk = nblk;
      n.dcnt = 16'h0000;
      n.cnt = 8'h00;
      c16_clr = 1'b1;
      if (!s.ctrl[C_MULTI] || (!s.ctrl[C_OPEN] && nblk == s.blkcnt))
      begin
        n.st = ST_IDLE;                                         // RULE3
        ev[I_TEND] = 1'b1;                                      // RULE3
        ev[I_BEND] = s.ctrl[C_MULTI];                           // RULE3
      end else begin
        n.st = s.ctrl[C_WRITE] ? ST_DTX : ST_DWAIT;
      end
    end
    ev[I_CRC] = crc_bad;                                        // RULE11
    // ----------------------------------------------------------------
    // Register access side effects
    // ----------------------------------------------------------------
    // A byte landing in the same cycle loses its full flag to the read
    if (rd && paddr == OFF_DATA && s.rx_full) begin
      n.rx_full = 1'b0;
    end
    if (rd && paddr == OFF_ISTS && s.sts[I_CRC]) begin
      n.crc_armed = 1'b1;                                       // RULE7
    end
    if (wr) begin
      case (paddr)
        OFF_ARG:   n.arg = pwdata;
        OFF_CTRL: begin
          n.read_continue_bit = pwdata[C_RDCONT];
          if (pwdata[C_ABORT]) begin
            n.st = ST_IDLE;                                     // RULE4
            n.pins.cmd_oe = 1'b0;
            n.pins.dat_oe = 1'b0;
            n.card_busy = 1'b0;
          end else if (s.st == ST_IDLE) begin
            n.ctrl = pwdata[12:0];
            if (pwdata[C_START]) begin
              n.st = ST_CMD;
              n.cnt = 8'h00;
              n.sh = {2'b01, pwdata[5:0], s.arg, 7'h00, 1'b1};
              c7_clr = 1'b1;
            end
          end
        end
        OFF_ISTS: begin
          sts_clr = pwdata[I_W-1:0];
          sts_clr[I_CRC] = ~pwdata[I_CRC] & s.crc_armed;        // RULE7
          if (sts_clr[I_CRC]) begin
            n.crc_armed = 1'b0;
          end
        end
        OFF_IMASK: n.mask = pwdata[I_W-1:0];
        OFF_BLK: begin
          if (s.st == ST_IDLE) begin
            n.blksz = pwdata[11:0];
            n.blkcnt = pwdata[31:16];
          end
        end
        OFF_DMA: begin
          // Locked while a sequence runs, so setup precedes the command
          if (s.st == ST_IDLE) begin
            n.dma = pwdata[1:0];                                // RULE1
          end
        end
        OFF_DATA: begin
          n.tx_byte = pwdata[7:0];
          n.tx_full = 1'b1;
        end
        OFF_CDIV:  n.cdiv = pwdata[7:0];
        OFF_RESPD: n.respd = pwdata[4:0];
        default: begin
          if (is_resp(paddr)) begin
            n.resp[resp_idx(paddr)] = pwdata[7:0];
          end
        end
      endcase
    end
    n.sts = (s.sts & ~sts_clr) | ev;
    n.irq = |(s.sts & s.mask);                                  // RULE11
    n.dma_req = s.dma[D_EN] & (((s.st == ST_DRX) & s.rx_full) |
                               ((s.st == ST_DTX) & ~s.tx_full));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.cdiv <= RST_CDIV;
      s.blksz <= RST_BLKSZ;
      s.blkcnt <= RST_BLKCNT;
      s.pins.cmd_o <= 1'b1;
      s.pins.dat_o <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign pins = s.pins;
  assign irq = s.irq;
  assign dma_req = s.dma_req;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_crc_flag;
    crc_bad |=> s.sts[I_CRC];
  endproperty
  a_crc_flag: assert property (p_crc_flag)  // RULE11
    else $error("crc mismatch did not set the error flag");

  property p_crc_irq;
    (crc_bad && s.mask[I_CRC]) |=> ##1 irq;
  endproperty
  a_crc_irq: assert property (p_crc_irq)  // RULE11
    else $error("enabled crc error did not raise irq");

  property p_abort;
    (wr && paddr == OFF_CTRL && pwdata[C_ABORT]) |=>
      (s.st == ST_IDLE && !pins.cmd_oe && !pins.dat_oe);
  endproperty
  a_abort: assert property (p_abort)  // RULE4
    else $error("abort did not stop the sequence");

  property p_tend_idle;
    $rose(s.sts[I_TEND]) |-> (s.st == ST_IDLE);
  endproperty
  a_tend_idle: assert property (p_tend_idle)  // RULE3
    else $error("transfer end flagged while sequence busy");

  property p_card_busy;
    (tick && s.st == ST_BUSY && !(wr && paddr == OFF_CTRL)) |=>
      (s.card_busy == !$past(s.dat_s2));
  endproperty
  a_card_busy: assert property (p_card_busy)  // RULE6
    else $error("card busy bit without low data line");

  property p_open_auto;
    (s.st == ST_DWAIT && s.ctrl[C_MULTI] && s.ctrl[C_OPEN] &&
     !s.read_continue_bit && s.blk != 16'h0 && !pins.clk) |=> !pins.clk;
  endproperty
  a_open_auto: assert property (p_open_auto)  // RULE2
    else $error("auto mode used on open-ended transfer");

  property p_pready_pulse;
    pready |=> !pready;
  endproperty
  a_pready_pulse: assert property (p_pready_pulse)
    else $error("pready held longer than one cycle");
endmodule
`default_nettype wire

// file: rtl/mmch_pkg.sv
// Shared constants and types for the card-link command sequencer.
// Assumes a 40 MHz APB clock and one command pin plus one data pin.
package mmch_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_ARG   = 8'h00;
  localparam logic [7:0] OFF_CTRL  = 8'h04;
  localparam logic [7:0] OFF_COMMAND_STATUS_REG  = 8'h08;
  localparam logic [7:0] OFF_ISTS  = 8'h0c;
  localparam logic [7:0] OFF_IMASK = 8'h10;
  localparam logic [7:0] OFF_BLK   = 8'h14;
  localparam logic [7:0] OFF_DMA   = 8'h18;
  localparam logic [7:0] OFF_DATA  = 8'h1c;
  localparam logic [7:0] OFF_CDIV  = 8'h20;
  localparam logic [7:0] OFF_RESP  = 8'h40;
  localparam logic [7:0] OFF_RESPD = 8'h84;
  localparam int         RESP_BYTES = 17;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int C_RESP   = 6;
  localparam int C_LONG   = 7;
  localparam int C_CRCCHK = 8;
  localparam int C_DATA   = 9;
  localparam int C_WRITE  = 10;
  localparam int C_MULTI  = 11;
  localparam int C_OPEN   = 12;
  localparam int C_START  = 16;
  localparam int C_ABORT  = 17;
  localparam int C_RDCONT = 18;
  localparam int I_RESP   = 0;
  localparam int I_TEND   = 1;
  localparam int I_BEND   = 2;
  localparam int I_CRC    = 3;
  localparam int I_TOUT   = 4;
  localparam int I_W      = 5;
  localparam int D_EN     = 0;
  localparam int D_AUTO   = 1;

  // ----------------------------------------------------------------
  // Reset values, cycle counts and CRC polynomials
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_CDIV     = 8'h31;
  localparam logic [11:0] RST_BLKSZ    = 12'h200;
  localparam logic [15:0] RST_BLKCNT   = 16'h0001;
  localparam logic [7:0]  CMD_BITS     = 8'h30;
  localparam logic [7:0]  LONG_BITS    = 8'h88;
  localparam logic [7:0]  CRC_SPAN     = 8'h28;
  localparam logic [7:0]  RESP_TMO     = 8'h40;
  localparam logic [7:0]  WR_TOKEN     = 8'h08;
  localparam logic [6:0]  CRC7_POLY    = 7'h09;
  localparam logic [15:0] CRC16_POLY   = 16'h1021;

  typedef enum logic [3:0] {
    ST_IDLE, ST_CMD, ST_RWAIT, ST_RESP, ST_BUSY,
    ST_DWAIT, ST_DRX, ST_DTX, ST_DBUSY
  } mmch_state_t;

  typedef struct packed {
    logic clk;
    logic cmd_o;
    logic cmd_oe;
    logic dat_o;
    logic dat_oe;
  } mmch_pins_t;

endpackage

// file: rtl/mmch_crc.sv
// Serial CRC generator, one bit per enable, MSB-first polynomial.
// Assumes clr and en come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module mmch_crc #(
  parameter int           W    = 7,
  parameter logic [W-1:0] POLY = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         clr,
  input  wire logic         en,
  input  wire logic         din,
  output logic [W-1:0]      crc
);
  logic [W-1:0] next_crc;

  always_comb begin
    next_crc = crc;
    if (clr) begin
      next_crc = '0;
    end else if (en) begin
      next_crc = {crc[W-2:0], 1'b0} ^ ((din ^ crc[W-1]) ? POLY : '0);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crc <= '0;
    end else begin
      crc <= next_crc;
    end
  end
endmodule
`default_nettype wire

// file: sim/mmch_card.sv
// Card model for the command and data lines of the sequencer.
// Assumes the host clocks it and both lines are pulled up when free.
`timescale 1ns/1ps
`default_nettype none
module mmch_card (
  input  wire mmch_pkg::mmch_pins_t pins,
  input  wire logic                 bad_crc,
  input  wire logic [15:0]          busy_ns,
  input  wire logic [1:0]           rd_blks,
  input  wire logic [7:0]           rd_bytes,
  output logic                      cmd_in,
  output logic                      dat_in
);
  import mmch_pkg::*;
  logic        c_oe;
  logic        c_o;
  logic        d_oe;
  logic        fb;
  logic [47:0] rx;
  logic [47:0] tx;
  logic [6:0]  crc;
  logic [15:0] dc;
  logic [7:0]  db;
  logic        d_o;
  logic        lost;
  int          i;
  int          b;
  // Released lines go to the pull-up level
  assign cmd_in = c_oe ? c_o : (pins.cmd_oe ? pins.cmd_o : 1'b1);
  assign dat_in = d_oe ? d_o : (pins.dat_oe ? pins.dat_o : 1'b1);
  initial begin
    c_oe = 1'b0;
    c_o = 1'b1;
    d_oe = 1'b0;
    d_o = 1'b0;
    forever begin
      @(posedge pins.clk);
      if (pins.cmd_oe && !pins.cmd_o) begin
        rx = '0;
        repeat (47) begin
          @(posedge pins.clk);
          rx = {rx[46:0], pins.cmd_o};
        end
        tx = {2'b00, rx[45:40], 32'h0000_0900, 8'h01};
        crc = '0;
        for (i = 47; i >= 8; i--) begin
          fb = tx[i] ^ crc[6];
          crc = {crc[5:0], 1'b0} ^ (fb ? CRC7_POLY : 7'h00);
        end
        tx[7:1] = crc ^ {6'h00, bad_crc};
        repeat (2) @(posedge pins.clk);
        lost = 1'b0;
        for (i = 47; i >= 0 && !lost; i--) begin
          c_oe = 1'b1;
          c_o = tx[i];
          if (i == 0) begin
            d_oe = (busy_ns != 16'h0000);
            d_o = 1'b0;
          end
          @(posedge pins.clk);
          lost = (cmd_in !== c_o);
        end
        c_oe = 1'b0;
        if (d_oe) begin
          #(busy_ns);
          d_oe = 1'b0;
        end
        // Read data blocks: start bit, bytes a0 upward, crc16, end bit
        for (b = 0; b < rd_blks && !lost; b++) begin
          repeat (2) @(posedge pins.clk);
          dc = '0;
          d_oe = 1'b1;
          d_o = 1'b0;
          for (i = 0; i < 8 * rd_bytes + 17; i++) begin
            @(posedge pins.clk);
            db = 8'ha0 + 8'(i / 8);
            if (i < 8 * rd_bytes) begin
              d_o = db[7 - i % 8];
              fb = d_o ^ dc[15];
              dc = {dc[14:0], 1'b0} ^ (fb ? CRC16_POLY : 16'h0000);
            end else if (i < 8 * rd_bytes + 16) begin
              d_o = dc[15];
              dc = {dc[14:0], 1'b0};
            end else begin
              d_o = 1'b1;
            end
          end
        end
        if (rd_blks != 2'b00 && !lost) begin
          @(posedge pins.clk);
          d_oe = 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench for the card-link sequencer over APB.
// Assumes the card model on the far side and a 40 MHz pclk.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mmch_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        cmd_in, dat_in, irq, bad_crc, err, dma_req;
  logic [1:0]  rd_blks;
  logic [7:0]  paddr, rd_bytes;
  logic [15:0] busy_ns;
  logic [31:0] pwdata, prdata, rd;
  mmch_pins_t  pins;
  int          failures, num_checks, n;
  int          cyc = 0;
  localparam logic [31:0] GO = 32'h0001_014d;
  localparam logic [31:0] RDGO = 32'h0005_0b52;

  mmch_seq uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmd_in(cmd_in),
    .dat_in(dat_in), .pins(pins), .irq(irq), .dma_req(dma_req));
  mmch_card card (.pins(pins), .bad_crc(bad_crc), .busy_ns(busy_ns),
    .rd_blks(rd_blks), .rd_bytes(rd_bytes),
    .cmd_in(cmd_in), .dat_in(dat_in));

  // ------------------------------------------------------------
  // Clock, timeout and access tasks
  // ------------------------------------------------------------
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      failures++;
      complete_run;
    end
  end
  task automatic complete_run;
    if (failures == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      failures++;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] e, m);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd & m);
  endtask
  task automatic poll(input logic [7:0] a, input logic [31:0] m, e);
    int k;
    k = 0;
    do begin
      apb(1'b0, a, 32'h0);
      k++;
    end while ((rd & m) !== e && k < 600);
    chk("poll", e, rd & m);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    bad_crc = 1'b0;
    busy_ns = 16'd3000;
    rd_blks = 2'd0;
    rd_bytes = 8'd2;
    failures = 0;
    num_checks = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rchk("cdiv", OFF_CDIV, 32'h31, '1);
    rchk("blk", OFF_BLK, 32'h0001_0200, '1);
    rchk("command_status_reg", OFF_COMMAND_STATUS_REG, 32'h0, '1);
    rchk("resp", OFF_RESP, 32'h0, '1);
    rchk("unmapped", 8'h3c, 32'h0, '1);
    chk("slverr", 32'h1, {31'h0, err});
    apb(1'b1, OFF_CDIV, 32'h3);
    apb(1'b1, OFF_ARG, 32'h1234_5678);
    apb(1'b1, OFF_CTRL, GO);
    poll(OFF_ISTS, 32'h1, 32'h1);
    rchk("resp0", OFF_RESP, 32'h0d, '1);
    rchk("resp3", OFF_RESP + 8'd12, 32'h09, '1);
    rchk("card_busy", OFF_COMMAND_STATUS_REG, 32'h3, 32'h3);
    poll(OFF_COMMAND_STATUS_REG, 32'h3, 32'h0);
    rchk("crc_ok", OFF_ISTS, 32'h0, 32'h8);
    apb(1'b1, OFF_ISTS, 32'h1);
    rchk("ists_clr", OFF_ISTS, 32'h0, '1);
    bad_crc <= 1'b1;
    busy_ns <= 16'd0;
    apb(1'b1, OFF_IMASK, 32'h8);
    apb(1'b1, OFF_CTRL, GO);
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    chk("irq_set", 32'h1, {31'h0, irq});
    apb(1'b1, OFF_IMASK, 32'h0);
    repeat (2) @(posedge pclk);
    chk("irq_masked", 32'h0, {31'h0, irq});
    apb(1'b1, OFF_IMASK, 32'h8);
    apb(1'b1, OFF_ISTS, 32'h0);
    poll(OFF_COMMAND_STATUS_REG, 32'h1, 32'h0);
    rchk("crc_kept", OFF_ISTS, 32'h8, 32'h8);
    apb(1'b1, OFF_ISTS, 32'h0);
    rchk("crc_clr", OFF_ISTS, 32'h0, 32'h8);
    chk("irq_clr", 32'h0, {31'h0, irq});
    bad_crc <= 1'b0;
    rd_blks <= 2'd2;
    apb(1'b1, OFF_BLK, 32'h0002_0002);
    apb(1'b1, OFF_DMA, 32'h1);
    apb(1'b1, OFF_CTRL, RDGO);
    for (n = 0; n < 4; n++) begin
      poll(OFF_COMMAND_STATUS_REG, 32'h4, 32'h4);
      chk("dma_req", 32'h1, {31'h0, dma_req});
      rchk("rx_data", OFF_DATA, 32'ha0 + (n % 2), '1);
    end
    poll(OFF_ISTS, 32'h6, 32'h6);
    rchk("rd_crc", OFF_ISTS, 32'h0, 32'h8);
    rchk("rd_idle", OFF_COMMAND_STATUS_REG, 32'h0, 32'h1);
    rd_blks <= 2'd0;
    apb(1'b1, OFF_CTRL, GO);
    apb(1'b1, OFF_CTRL, 32'h0002_0000);
    rchk("abort", OFF_COMMAND_STATUS_REG, 32'h0, 32'h1);
    complete_run;
  end
endmodule
`default_nettype wire
